// File: verilog/mtc_pkg.sv
// Constants and types shared by both ends of the command link
`default_nettype none
package mtc_pkg;
  localparam int CLK_MHZ = 40;
  localparam int CAL_MAX_US = 3000;
  localparam int CAP_MAX_US = 250;
  localparam int SUP_MAX_NS = 25000;
  localparam int CAL_CYCLES = CAL_MAX_US * CLK_MHZ;
  localparam int CAP_CYCLES = CAP_MAX_US * CLK_MHZ;
  localparam int SUP_CYCLES = (SUP_MAX_NS * CLK_MHZ) / 1000;
  localparam int CNT_W = 17;
  // Link opcodes in bits 7:6 of the command byte (first byte, or the one after test access)
  localparam logic [1:0] OPC_WRITE = 2'h0;
  localparam logic [1:0] OPC_READ = 2'h1;
  localparam logic [1:0] OPC_DIRECT = 2'h3;
  localparam logic [5:0] CMD_TRANSPARENT = 6'h10;
  localparam logic [5:0] CMD_CAL_CAP = 6'h11;
  localparam logic [5:0] CMD_MEAS_CAP = 6'h12;
  localparam logic [5:0] CMD_MEAS_SUPPLY = 6'h13;
  localparam logic [5:0] CMD_TEST_ACCESS = 6'h14;
  // Device register space
  localparam logic [5:0] ADDR_ADC_OUT = 6'h25;
  localparam logic [5:0] ADDR_REG_CTRL = 6'h2c;
  localparam logic [5:0] ADDR_CAP_CTRL = 6'h2f;
  localparam logic [5:0] ADDR_CAP_DISP = 6'h30;
  localparam logic [5:0] TADDR_OBS = 6'h01;
  localparam logic [7:0] OBS_RESET = 8'h40;
  localparam int SUP_SEL_MSB = 2;
  localparam int MCAL_LSB = 3;
  localparam int DISP_BUSY = 0;
  localparam int DISP_OK = 1;
  localparam int DISP_ERR = 2;
  // Host controller APB map
  localparam logic [7:0] HADDR_CTRL = 8'h00;
  localparam logic [7:0] HADDR_TX = 8'h04;
  localparam logic [7:0] HADDR_RX = 8'h08;
  localparam logic [7:0] HADDR_STAT = 8'h0c;
  localparam logic [2:0] MAX_BYTES = 3'd4;
  typedef enum logic [1:0] {OP_CMD = 2'b00, OP_WR = 2'b01, OP_RD = 2'b11, OP_NONE = 2'b10} op_t;
  typedef enum logic [1:0] {M_IDLE = 2'b00, M_CAL = 2'b01, M_CAP = 2'b11, M_SUP = 2'b10} meas_t;
  typedef enum logic {H_IDLE = 1'b0, H_RUN = 1'b1} hstate_t;
endpackage
`default_nettype wire

// File: verilog/serial_link_if.sv
// Serial command link between host controller and device
`default_nettype none
interface serial_link_if;
  logic sclk;
  logic mosi;
  logic miso;
  logic serial_select_n;
  modport host (output sclk, output mosi, output serial_select_n, input miso);
  modport dev (input sclk, input mosi, input serial_select_n, output miso);
endinterface
`default_nettype wire

// File: verilog/meas_test_dev.sv
// Device end: command decode, measurements, test access and pin routing
//
// Local design decision: the APB interface to the registers.
`default_nettype none
module meas_test_dev #(
  parameter int CAL_CYCLES_P = mtc_pkg::CAL_CYCLES,
  parameter int CAP_CYCLES_P = mtc_pkg::CAP_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  serial_link_if.dev link,
  input wire logic ready_mode_i,
  input wire logic [9:0] supply_raw_i,
  input wire logic [7:0] cap_raw_i,
  input wire logic [15:0] obs_drive_i,
  input wire logic [15:0] obs_out_i,
  input wire logic cap_drive_normal_i,
  input wire logic cap_out_normal_i,
  output logic cap_sensor_drive_pin_o,
  output logic cap_sensor_out_pin_o,
  output logic test_mode_o,
  output logic transparent_o,
  output logic tx_direct_o,
  output logic [2:0] supply_sel_o,
  output logic busy_o,
  output logic cap_irq_o
);
  import mtc_pkg::*;

  function automatic logic obs_listed(input logic [3:0] c);
    obs_listed = (c >= 4'h1 && c <= 4'h7) || (c >= 4'hb && c <= 4'he);
  endfunction

  ////////////////////////////////////////////////////////////////////
  logic sclk_d_reg, ss_d_reg, miso_reg;
  logic [2:0] bit_reg;
  logic [7:0] rx_sh_reg, tx_sh_reg;
  op_t op_reg;
  logic [5:0] addr_reg;
  logic test_reg, transp_pend_reg, transparent_reg, tx_direct_reg;
  logic [7:0] reg_ctrl_reg, cap_ctrl_reg, cap_disp_reg, adc_reg, obs_reg;
  meas_t meas_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic busy_reg, irq_reg, drive_pin_reg, out_pin_reg, test_mode_reg;

  wire in_frame = ~link.serial_select_n;
  wire sclk_rise = link.sclk & ~sclk_d_reg;
  wire sclk_fall = ~link.sclk & sclk_d_reg;
  wire ss_fall = ~link.serial_select_n & ss_d_reg;
  wire ss_rise = link.serial_select_n & ~ss_d_reg;
  wire [7:0] rx_byte = {rx_sh_reg[6:0], link.mosi};
  wire byte_done = in_frame & sclk_rise & (bit_reg == 3'd7);
  wire cmd_byte = byte_done & (op_reg == OP_CMD);
  wire is_direct = rx_byte[7:6] == OPC_DIRECT;
  wire is_read = rx_byte[7:6] == OPC_READ;
  wire direct = cmd_byte & is_direct;
  wire [5:0] code = rx_byte[5:0];
  wire rd_load = (cmd_byte & is_read) | (byte_done & (op_reg == OP_RD));
  wire wr_en = byte_done & (op_reg == OP_WR);
  wire [5:0] rd_addr = (op_reg == OP_CMD) ? code : addr_reg;
  // Test space holds only the observation register; all else reads zero
  wire [7:0] rd_test = (rd_addr == TADDR_OBS) ? obs_reg : 8'h00;
  wire [7:0] rd_norm = (rd_addr == ADDR_ADC_OUT) ? adc_reg :
                       (rd_addr == ADDR_REG_CTRL) ? reg_ctrl_reg :
                       (rd_addr == ADDR_CAP_CTRL) ? cap_ctrl_reg :
                       (rd_addr == ADDR_CAP_DISP) ? cap_disp_reg : 8'h00;
  wire [7:0] rd_data = test_reg ? rd_test : rd_norm;
  wire [5:0] addr_next = (op_reg == OP_CMD) ? (is_read ? code + 6'd1 : code) : addr_reg + 6'd1;
  wire mcal_zero = cap_ctrl_reg[7:MCAL_LSB] == '0;
  wire meas_idle = meas_reg == M_IDLE;
  wire start_cal = direct & (code == CMD_CAL_CAP) & mcal_zero & meas_idle;
  wire start_cap = direct & (code == CMD_MEAS_CAP) & meas_idle;
  wire start_sup = direct & (code == CMD_MEAS_SUPPLY) & meas_idle;
  wire [CNT_W-1:0] limit = (meas_reg == M_CAL) ? CNT_W'(CAL_CYCLES_P - 1) :
                           (meas_reg == M_CAP) ? CNT_W'(CAP_CYCLES_P - 1) :
                           CNT_W'(SUP_CYCLES - 1);
  wire meas_end = ~meas_idle & (cnt_reg == limit);
  wire [9:0] sup_div = supply_raw_i / 10'd3;
  wire [7:0] sup_res = (sup_div[9:8] != 2'b00) ? 8'hff : sup_div[7:0];
  wire cal_good = cap_raw_i != 8'hff;
  wire [3:0] obs_code = obs_reg[3:0];
  wire listed = obs_listed(obs_code);

  ////////////////////////////////////////////////////////////////////
  // Serial frame receiver; frame state clears at each select fall
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sclk_d_reg <= 1'b0;
      ss_d_reg <= 1'b1;
      bit_reg <= 3'd0;
      rx_sh_reg <= 8'h00;
      op_reg <= OP_NONE;
      addr_reg <= 6'h00;
      test_reg <= 1'b0;
    end else begin
      sclk_d_reg <= link.sclk;
      ss_d_reg <= link.serial_select_n;
      if (ss_fall) begin
        bit_reg <= 3'd0;
        op_reg <= OP_CMD;
        test_reg <= 1'b0;
      end else if (in_frame & sclk_rise) begin
        bit_reg <= bit_reg + 3'd1;
        rx_sh_reg <= rx_byte;
        if (cmd_byte & is_direct) begin
          op_reg <= (code == CMD_TEST_ACCESS) ? OP_CMD : OP_NONE;
          test_reg <= code == CMD_TEST_ACCESS;
        end else if (cmd_byte) begin
          op_reg <= is_read ? OP_RD : OP_WR;
        end
        if (cmd_byte | byte_done & (op_reg == OP_WR | op_reg == OP_RD)) begin
          addr_reg <= addr_next;
        end
      end
    end
  end

  // Read data shifts out on falls so it is stable at the host's rise
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i | ss_fall) begin
      tx_sh_reg <= 8'h00;
      miso_reg <= 1'b0;
    end else if (rd_load) begin
      tx_sh_reg <= rd_data;
    end else if (in_frame & sclk_fall) begin
      miso_reg <= tx_sh_reg[7];
      tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
    end
  end
  assign link.miso = miso_reg;

  ////////////////////////////////////////////////////////////////////
  // Transparent mode latches at frame end, drops at next frame start
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      transp_pend_reg <= 1'b0;
      transparent_reg <= 1'b0;
      tx_direct_reg <= 1'b0;
    end else begin
      if (ss_fall) begin
        transp_pend_reg <= 1'b0;
        transparent_reg <= 1'b0;
      end else begin
        if (direct & (code == CMD_TRANSPARENT)) begin
          transp_pend_reg <= 1'b1;
        end
        if (ss_rise & transp_pend_reg) begin
          transparent_reg <= 1'b1;
        end
      end
      tx_direct_reg <= transparent_reg & link.mosi;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register file; test space reset values apply at every sys_rst_i
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      reg_ctrl_reg <= 8'h00;
      cap_ctrl_reg <= 8'h00;
      obs_reg <= OBS_RESET;
    end else if (wr_en & test_reg) begin
      if (addr_reg == TADDR_OBS) begin
        obs_reg <= rx_byte;
      end
    end else if (wr_en) begin
      if (addr_reg == ADDR_REG_CTRL) begin
        reg_ctrl_reg <= rx_byte;
      end
      if (addr_reg == ADDR_CAP_CTRL) begin
        cap_ctrl_reg <= rx_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Measurements run the full worst-case time; starts while not idle are ignored
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      meas_reg <= M_IDLE;
      cnt_reg <= '0;
      adc_reg <= 8'h00;
      cap_disp_reg <= 8'h00;
      irq_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      irq_reg <= 1'b0;
      busy_reg <= ~meas_idle;
      cnt_reg <= meas_idle ? '0 : cnt_reg + CNT_W'(1);
      if (start_cal) begin
        meas_reg <= M_CAL;
        cap_disp_reg <= 8'h01 << DISP_BUSY;
      end else if (start_cap) begin
        meas_reg <= M_CAP;
      end else if (start_sup) begin
        meas_reg <= M_SUP;
      end else if (meas_end) begin
        meas_reg <= M_IDLE;
        unique case (meas_reg)
          M_CAL: begin
            cap_disp_reg <= 8'h01 << (cal_good ? DISP_OK : DISP_ERR);
            irq_reg <= ready_mode_i;
          end
          M_CAP: adc_reg <= cap_raw_i;
          M_SUP: adc_reg <= sup_res;
          M_IDLE: adc_reg <= adc_reg;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sensor pins double as test pins for listed observation codes
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      drive_pin_reg <= 1'b0;
      out_pin_reg <= 1'b0;
      test_mode_reg <= 1'b0;
    end else begin
      test_mode_reg <= listed;
      drive_pin_reg <= listed ? obs_drive_i[obs_code] : cap_drive_normal_i;
      out_pin_reg <= listed ? obs_out_i[obs_code] : cap_out_normal_i;
    end
  end

  assign cap_sensor_drive_pin_o = drive_pin_reg;
  assign cap_sensor_out_pin_o = out_pin_reg;
  assign test_mode_o = test_mode_reg;
  assign transparent_o = transparent_reg;
  assign tx_direct_o = tx_direct_reg;
  assign supply_sel_o = reg_ctrl_reg[SUP_SEL_MSB:0];
  assign busy_o = busy_reg;
  assign cap_irq_o = irq_reg;
endmodule
`default_nettype wire

// File: verilog/meas_test_host.sv
// Host end: APB-controlled serial frame engine
`default_nettype none
module meas_test_host (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic frame_done_o,
  serial_link_if.host link
);
  import mtc_pkg::*;

  ////////////////////////////////////////////////////////////////////
  hstate_t state_reg;
  logic pready_reg, pslverr_reg, done_reg, sclk_reg, mosi_reg, ss_n_reg;
  logic [31:0] prdata_reg, tx_reg, tx_sh_reg, rx_sh_reg;
  logic [2:0] nbytes_reg;
  logic [5:0] bits_reg;
  logic [1:0] cyc_reg;

  wire acc = psel_i & penable_i & ~pready_reg;
  wire fin = psel_i & penable_i & pready_reg;
  wire mapped = paddr_i == HADDR_CTRL | paddr_i == HADDR_TX | paddr_i == HADDR_RX | paddr_i == HADDR_STAT;
  wire [2:0] req_n = pwdata_i[2:0];
  // Count 0 or above four is refused; a busy engine ignores starts too
  wire start = fin & pwrite_i & (paddr_i == HADDR_CTRL) & (state_reg == H_IDLE) &
               (req_n != 3'd0) & (req_n <= MAX_BYTES);
  wire [31:0] rd_mux = (paddr_i == HADDR_CTRL) ? {29'h0, nbytes_reg} :
                       (paddr_i == HADDR_TX) ? tx_reg :
                       (paddr_i == HADDR_RX) ? rx_sh_reg :
                       (paddr_i == HADDR_STAT) ? {31'h0, state_reg == H_RUN} : 32'h0;
  wire [31:0] tx_order = {tx_reg[7:0], tx_reg[15:8], tx_reg[23:16], tx_reg[31:24]};
  wire last_bit = bits_reg == 6'd1;

  ////////////////////////////////////////////////////////////////////
  // Answer one cycle into the access phase
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
      tx_reg <= 32'h0;
    end else begin
      pready_reg <= acc;
      pslverr_reg <= acc & ~mapped;
      if (acc) begin
        prdata_reg <= rd_mux;
      end
      if (fin & pwrite_i & (paddr_i == HADDR_TX)) begin
        tx_reg <= pwdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Four system clocks per serial bit; a new frame start ends transparency
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_reg <= H_IDLE;
      ss_n_reg <= 1'b1;
      sclk_reg <= 1'b0;
      mosi_reg <= 1'b0;
      tx_sh_reg <= 32'h0;
      rx_sh_reg <= 32'h0;
      nbytes_reg <= 3'd0;
      bits_reg <= 6'd0;
      cyc_reg <= 2'd0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      unique case (state_reg)
        H_IDLE: begin
          if (start) begin
            state_reg <= H_RUN;
            ss_n_reg <= 1'b0;
            nbytes_reg <= req_n;
            bits_reg <= {req_n, 3'b000};
            tx_sh_reg <= tx_order;
            mosi_reg <= tx_order[31];
            cyc_reg <= 2'd0;
          end
        end
        H_RUN: begin
          cyc_reg <= cyc_reg + 2'd1;
          if (cyc_reg == 2'd1) begin
            sclk_reg <= 1'b1;
            rx_sh_reg <= {rx_sh_reg[30:0], link.miso};
          end
          if (cyc_reg == 2'd3) begin
            sclk_reg <= 1'b0;
            bits_reg <= bits_reg - 6'd1;
            tx_sh_reg <= {tx_sh_reg[30:0], 1'b0};
            mosi_reg <= tx_sh_reg[30];
            if (last_bit) begin
              state_reg <= H_IDLE;
              ss_n_reg <= 1'b1;
              mosi_reg <= 1'b0;
              done_reg <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign frame_done_o = done_reg;
  assign link.sclk = sclk_reg;
  assign link.mosi = mosi_reg;
  assign link.serial_select_n = ss_n_reg;
endmodule
`default_nettype wire

// File: verif/mtc_link_properties.sv
// Concurrent checks on the command link and device outputs
`default_nettype none
module mtc_link_properties #(
  parameter int CAL_CYCLES_P = 50,
  parameter int CAP_CYCLES_P = 20
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic serial_select_n,
  input wire logic transparent_o,
  input wire logic tx_direct_o,
  input wire logic busy_o,
  input wire logic cap_irq_o,
  input wire logic ready_mode_i,
  input wire logic test_mode_o,
  input wire logic cap_sensor_out_pin_o,
  input wire logic cap_out_normal_i
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int M1 = CAL_CYCLES_P > CAP_CYCLES_P ? CAL_CYCLES_P : CAP_CYCLES_P;
  // Two spare cycles cover the busy flag lag
  localparam int BUSY_MAX = (M1 > mtc_pkg::SUP_CYCLES ? M1 : mtc_pkg::SUP_CYCLES) + 2;
  int busy_cnt;
  int low_cnt;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      busy_cnt <= 0;
      low_cnt <= 0;
    end else begin
      busy_cnt <= busy_o ? busy_cnt + 1 : 0;
      low_cnt <= serial_select_n ? 0 : low_cnt + 1;
    end
  end
  ////////////////////////////////////////////////////////////////
  a_sclk_idle_low: assert property (serial_select_n |-> !sclk)
    else $error("serial clock high outside a frame");
  a_sclk_high_two: assert property ($rose(sclk) |=> sclk ##1 !sclk)
    else $error("serial clock high phase not two cycles");
  a_frame_whole_bytes: assert property ($rose(serial_select_n) |-> low_cnt != 0 && low_cnt % 32 == 0)
    else $error("frame length not whole bytes");
  a_tm_begin_idle: assert property ($rose(transparent_o) |-> serial_select_n)
    else $error("transparent mode began inside a frame");
  a_tm_end_frame: assert property ($fell(serial_select_n) |-> ##[0:2] !transparent_o)
    else $error("transparent mode outlived next frame start");
  a_tx_follows_data: assert property ($past(transparent_o) |-> tx_direct_o == $past(mosi))
    else $error("transmitter not following data line");
  a_irq_ready_only: assert property (cap_irq_o |-> $past(ready_mode_i))
    else $error("detect interrupt outside ready mode");
  a_irq_one_pulse: assert property (cap_irq_o |=> !cap_irq_o)
    else $error("detect interrupt longer than one cycle");
  a_busy_bounded: assert property (busy_cnt <= BUSY_MAX)
    else $error("measurement ran too long");
  a_pins_normal: assert property (!test_mode_o && !$past(sys_rst_i) |->
    cap_sensor_out_pin_o == $past(cap_out_normal_i))
    else $error("sensor pin not normal without test code");
endmodule
`default_nettype wire

// File: verif/measure_test_command_unit_tb.sv
// Bench joining host and device ends over the command link
`default_nettype none
module measure_test_command_unit_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import mtc_pkg::*;
  localparam int CAL_P = 50;
  localparam int CAP_P = 20;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o;
  logic pready_o, pslverr_o, frame_done_o;
  logic ready_mode_i = 1'b1;
  logic [9:0] supply_raw_i = 10'h000;
  logic [7:0] cap_raw_i = 8'h20;
  logic [15:0] obs_drive_i = 16'h5a3c;
  logic [15:0] obs_out_i = 16'ha5c3;
  logic cap_drive_normal_i = 1'b1, cap_out_normal_i = 1'b0;
  logic drv_pin, out_pin, test_mode, transp, tx_dir, busy, irq;
  logic [2:0] sup_sel;
  int err_count = 0, n_compared = 0, cyc = 0, irq_n = 0;
  // Supply rows: selector, raw input, expected result
  logic [2:0] sel_t [4] = '{3'h0, 3'h3, 3'h5, 3'h7};
  logic [9:0] raw_t [4] = '{10'h000, 10'h12c, 10'h2fa, 10'h3ff};
  logic [7:0] res_t [4] = '{8'h00, 8'h64, 8'hfe, 8'hff};
  serial_link_if link();
  meas_test_host u_meas_test_host (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .frame_done_o(frame_done_o), .link(link.host));
  meas_test_dev #(.CAL_CYCLES_P(CAL_P), .CAP_CYCLES_P(CAP_P)) u_meas_test_dev (.clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i), .link(link.dev), .ready_mode_i(ready_mode_i), .supply_raw_i(supply_raw_i),
    .cap_raw_i(cap_raw_i), .obs_drive_i(obs_drive_i), .obs_out_i(obs_out_i),
    .cap_drive_normal_i(cap_drive_normal_i), .cap_out_normal_i(cap_out_normal_i),
    .cap_sensor_drive_pin_o(drv_pin), .cap_sensor_out_pin_o(out_pin), .test_mode_o(test_mode),
    .transparent_o(transp), .tx_direct_o(tx_dir), .supply_sel_o(sup_sel), .busy_o(busy), .cap_irq_o(irq));
  mtc_link_properties #(.CAL_CYCLES_P(CAL_P), .CAP_CYCLES_P(CAP_P)) u_props (.clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i), .sclk(link.sclk), .mosi(link.mosi), .serial_select_n(link.serial_select_n),
    .transparent_o(transp), .tx_direct_o(tx_dir), .busy_o(busy), .cap_irq_o(irq), .ready_mode_i(ready_mode_i),
    .test_mode_o(test_mode), .cap_sensor_out_pin_o(out_pin), .cap_out_normal_i(cap_out_normal_i));
  ////////////////////////////////////////////////////////////////
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  task report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Ceiling sits well above the full sequence length
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (irq === 1'b1)
      irq_n <= irq_n + 1;
    if (cyc == 40000) begin
      err_count++;
      report_and_stop();
    end
  end
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task frame(input logic [31:0] tx, input logic [2:0] n);
    logic [31:0] r;
    logic e;
    apb(1'b1, HADDR_TX, tx, r, e);
    apb(1'b1, HADDR_CTRL, {29'h0, n}, r, e);
    do @(posedge clk_sys_i); while (frame_done_o !== 1'b1);
  endtask
  task wr(input logic t, input logic [5:0] a, input logic [7:0] d);
    if (t)
      frame({8'h00, d, OPC_WRITE, a, OPC_DIRECT, CMD_TEST_ACCESS}, 3'd3);
    else
      frame({16'h0, d, OPC_WRITE, a}, 3'd2);
  endtask
  task rd(input logic t, input logic [5:0] a, output logic [7:0] v);
    logic [31:0] r;
    logic e;
    if (t)
      frame({16'h0, OPC_READ, a, OPC_DIRECT, CMD_TEST_ACCESS}, 3'd3);
    else
      frame({24'h0, OPC_READ, a}, 3'd2);
    apb(1'b0, HADDR_RX, 32'h0, r, e);
    v = r[7:0];
  endtask
  task meas(input logic [5:0] cmd, output int c);
    frame({24'h0, OPC_DIRECT, cmd}, 3'd1);
    c = 0;
    while (busy === 1'b1 && c < 5000) begin
      @(posedge clk_sys_i);
      c++;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v;
    logic [31:0] r;
    logic e;
    int c;
    logic lst;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    chk("select idle", 8'h01, {7'h0, link.serial_select_n});
    chk("busy idle", 8'h00, {7'h0, busy});
    for (int k = 0; k < 4; k++) begin
      supply_raw_i <= raw_t[k];
      wr(1'b0, ADDR_REG_CTRL, {5'h0, sel_t[k]});
      chk("supply select", {5'h0, sel_t[k]}, {5'h0, sup_sel});
      meas(CMD_MEAS_SUPPLY, c);
      chk("supply time", 8'h01, {7'h0, c > 0 && c <= SUP_CYCLES});
      rd(1'b0, ADDR_ADC_OUT, v);
      chk("supply result", res_t[k], v);
    end
    rd(1'b1, TADDR_OBS, v);
    chk("obs default", 8'h40, v);
    wr(1'b0, TADDR_OBS, 8'h0f);
    rd(1'b1, TADDR_OBS, v);
    chk("obs unreached", 8'h40, v);
    for (int k = 0; k < 16; k++) begin
      lst = k inside {[1:7], [11:14]};
      // Normal pin values move so a stuck pin cannot pass
      cap_out_normal_i <= k[0];
      cap_drive_normal_i <= ~k[1];
      wr(1'b1, TADDR_OBS, {4'h4, k[3:0]});
      @(posedge clk_sys_i);
      chk("test mode", {7'h0, lst}, {7'h0, test_mode});
      chk("drive pin", {7'h0, lst ? obs_drive_i[k] : cap_drive_normal_i}, {7'h0, drv_pin});
      chk("out pin", {7'h0, lst ? obs_out_i[k] : cap_out_normal_i}, {7'h0, out_pin});
      rd(1'b1, TADDR_OBS, v);
      chk("obs readback", {4'h4, k[3:0]}, v);
    end
    wr(1'b0, ADDR_CAP_CTRL, 8'h00);
    meas(CMD_CAL_CAP, c);
    chk("cal time", 8'h01, {7'h0, c > 0 && c <= CAL_P});
    chk("irq ready", 8'h01, irq_n[7:0]);
    rd(1'b0, ADDR_CAP_DISP, v);
    chk("cal ok", 8'h02, v & 8'h07);
    ready_mode_i <= 1'b0;
    cap_raw_i <= 8'hff;
    meas(CMD_CAL_CAP, c);
    chk("irq not ready", 8'h01, irq_n[7:0]);
    rd(1'b0, ADDR_CAP_DISP, v);
    chk("cal err", 8'h04, v & 8'h07);
    wr(1'b0, ADDR_CAP_CTRL, 8'h08);
    meas(CMD_CAL_CAP, c);
    chk("cal manual", 8'h00, c[7:0]);
    meas(CMD_MEAS_CAP, c);
    chk("cap time", 8'h01, {7'h0, c > 0 && c <= CAP_P});
    frame({24'h0, OPC_DIRECT, CMD_TRANSPARENT}, 3'd1);
    @(posedge clk_sys_i);
    chk("transparent on", 8'h01, {7'h0, transp});
    // Next frame opens with a high data bit while still transparent
    frame({24'h0, OPC_DIRECT, CMD_TRANSPARENT}, 3'd1);
    @(posedge clk_sys_i);
    chk("transparent again", 8'h01, {7'h0, transp});
    rd(1'b0, ADDR_CAP_DISP, v);
    chk("transparent off", 8'h00, {7'h0, transp});
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk("unmapped", 8'h01, {7'h0, e});
    // Mid-run reset must restore the test register default
    wr(1'b1, TADDR_OBS, 8'h4b);
    @(posedge clk_sys_i);
    chk("test mode set", 8'h01, {7'h0, test_mode});
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    chk("reset test mode", 8'h00, {7'h0, test_mode});
    rd(1'b1, TADDR_OBS, v);
    chk("obs after reset", 8'h40, v);
    report_and_stop();
  end
endmodule
`default_nettype wire
